// >>> hdl/synth_cfg_consts.svh
// Named constants of the clock synthesizer configuration port.
// Assumes inclusion by bare name from the package and both ends.
`ifndef SYNTH_CFG_CONSTS_SVH
`define SYNTH_CFG_CONSTS_SVH
// ****************************************************************
// Addressing
// ****************************************************************
`define SLAVE_ADDR_HIGH 6'h30
`define BYTE_BITS 4'h8
`define REG_LAST 8'h04
`define REG_DIV_AB 3'h0
`define REG_DIV_C 3'h1
`define REG_FB_HIGH 3'h2
`define REG_FB_LOW_CTL 3'h3
`define REG_CDIS 3'h4
// ****************************************************************
// Reset values and field layout
// ****************************************************************
`define DEF_DIV_AB 8'h1E
`define DEF_DIV_C 8'h1E
`define DEF_FB_HIGH 8'h50
`define DEF_FB_LOW_CTL 8'h00
`define DEF_CDIS 8'h0B
`define DEF_FB 11'h280
`define MASK_DIV 8'h7E
`define MASK_FB_LOW_CTL 8'hF3
`define MASK_CTL_ONLY 8'h13
`define MASK_FB_LOW 8'hE0
`define MASK_CDIS 8'hF0
`define CDIS_RSVD 8'h0B
`define MARGIN_BIT 4
`define REF1_DIS_BIT 1
`define REF0_DIS_BIT 0
`define FB_MIN 11'h004
`define FB_MAX 11'h3FF
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 4
`define SCL_QUARTER_NS 252
`define SCL_QUARTER_CYC (`SCL_QUARTER_NS / `CLK_PERIOD_NS)
`endif

// >>> hdl/synth_cfg_pkg.sv
// Types shared by both ends of the configuration port.
// Assumes the constants header sits beside it.
`include "synth_cfg_consts.svh"
package synth_cfg_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } dev_state_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} host_state_t;
endpackage : synth_cfg_pkg

// >>> hdl/two_wire_if.sv
// Open-drain two-wire link joining the host end and the device end.
// Assumes each party pulls low only while its enable is high.
interface two_wire_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // A released line floats high through the pull-up.
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
  modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
  modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface : two_wire_if

// >>> hdl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes only the second stage is read downstream.
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      // Parking high matches a released pulled-up line, so no false edge follows reset.
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
    end
  end
  assign sync = sync_r;
endmodule : pin_sync

// >>> hdl/synth_cfg_device.sv
// Device end: two-wire slave and five-byte divider register bank.
// Assumes pins are asynchronous and the host keeps the bus protocol.
//
`include "synth_cfg_consts.svh"
module synth_cfg_device
  import synth_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  two_wire_if.dev bus,
  input wire logic addr_select_strap,
  input wire logic spread_enable_pin,
  input wire logic master_reset_pin,
  input wire logic reference_enable_pin,
  input wire logic bank_c_enable_pin,
  output logic [7:0] divider_banks_ab,
  output logic [7:0] divider_bank_c,
  output logic [10:0] feedback_divider,
  output logic feedback_in_range,
  output logic margin_enable,
  output logic reference_out_zero,
  output logic reference_out_one,
  output logic [3:0] bank_c_out_en
);
  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  logic [6:0] pins;
  logic scl_s, sda_s, sel_s, spread_s, mr_s, ref_en_s, c_en_s;
  logic scl_d_r, sda_d_r, mr_d_r, start_ev, stop_ev, scl_rise, scl_fall, mr_release;
  pin_sync #(.WIDTH(7)) u_sync (
    .clk(clk),
    .reset(reset),
    .pin({bus.scl, bus.sda, addr_select_strap, spread_enable_pin, master_reset_pin,
          reference_enable_pin, bank_c_enable_pin}),
    .sync(pins)
  );
  assign {scl_s, sda_s, sel_s, spread_s, mr_s, ref_en_s, c_en_s} = pins;
  // The reset value high keeps a released idle bus from looking like a stop or an scl rise.
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      mr_d_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      mr_d_r <= mr_s;
    end
  end
  assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign mr_release = mr_d_r & ~mr_s;
  // ****************************************************************
  // Serial engine and register bank
  // ****************************************************************
  dev_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, rd_byte;
  logic rw_r, rw_nxt, nack_r, nack_nxt, drv_r, drv_nxt, ptr_ok;
  logic [7:0] regs_r [0:4], regs_nxt [0:4];
  assign ptr_ok = (ptr_r <= `REG_LAST);
  assign rd_byte = ptr_ok ? regs_r[ptr_r[2:0]] : 8'h00;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    drv_nxt = drv_r;
    for (int i = 0; i <= 4; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    if (start_ev) begin
      st_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      drv_nxt = 1'b0;
    end else if (stop_ev) begin
      st_nxt = ST_IDLE;
      drv_nxt = 1'b0;
    end else if (scl_rise) begin
      if (st_r == ST_ADDR || st_r == ST_PTR || st_r == ST_WR) begin
        sh_nxt = {sh_r[6:0], sda_s};
        cnt_nxt = cnt_r + 4'h1;
      end else if (st_r == ST_RD) begin
        cnt_nxt = cnt_r + 4'h1;
      end else if (st_r == ST_RD_ACK) begin
        nack_nxt = sda_s;
      end
    end else if (scl_fall) begin
      unique case (st_r)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (cnt_r == `BYTE_BITS) begin
            if (sh_r[7:1] == {`SLAVE_ADDR_HIGH, sel_s}) begin
              st_nxt = ST_ADDR_ACK;
              drv_nxt = 1'b1;
              rw_nxt = sh_r[0];
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        ST_PTR: begin
          if (cnt_r == `BYTE_BITS) begin
            ptr_nxt = sh_r;
            st_nxt = ST_PTR_ACK;
            drv_nxt = 1'b1;
          end
        end
        ST_WR: begin
          if (cnt_r == `BYTE_BITS) begin
            if (ptr_ok) begin
              unique case (ptr_r[2:0])
                `REG_DIV_AB: regs_nxt[0] = sh_r & `MASK_DIV;
                `REG_DIV_C: regs_nxt[1] = sh_r & `MASK_DIV;
                `REG_FB_HIGH: regs_nxt[2] = spread_s ? regs_r[2] : sh_r;
                `REG_FB_LOW_CTL: regs_nxt[3] = spread_s ? ((regs_r[3] & `MASK_FB_LOW) | (sh_r & `MASK_CTL_ONLY))
                                                        : (sh_r & `MASK_FB_LOW_CTL);
                default: regs_nxt[4] = (sh_r & `MASK_CDIS) | `CDIS_RSVD;
              endcase
            end
            ptr_nxt = ptr_r + 8'h01;
            st_nxt = ST_WR_ACK;
            drv_nxt = 1'b1;
          end
        end
        ST_ADDR_ACK: begin
          st_nxt = ST_PTR;
          cnt_nxt = 4'h0;
          drv_nxt = 1'b0;
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          cnt_nxt = 4'h0;
          if (rw_r && st_r == ST_PTR_ACK) begin
            st_nxt = ST_RD;
            sh_nxt = rd_byte;
            drv_nxt = ~rd_byte[7];
          end else begin
            st_nxt = ST_WR;
            drv_nxt = 1'b0;
          end
        end
        ST_RD: begin
          if (cnt_r == `BYTE_BITS) begin
            st_nxt = ST_RD_ACK;
            drv_nxt = 1'b0;
            ptr_nxt = ptr_r + 8'h01;
          end else begin
            sh_nxt = {sh_r[6:0], 1'b0};
            drv_nxt = ~sh_r[6];
          end
        end
        ST_RD_ACK: begin
          cnt_nxt = 4'h0;
          if (nack_r) begin
            st_nxt = ST_IDLE;
          end else begin
            st_nxt = ST_RD;
            sh_nxt = rd_byte;
            drv_nxt = ~rd_byte[7];
          end
        end
      endcase
    end
    // Reloading after the bus update makes a master reset release win over a write.
    if (mr_release) begin
      regs_nxt[0] = `DEF_DIV_AB;
      regs_nxt[1] = `DEF_DIV_C;
      regs_nxt[2] = `DEF_FB_HIGH;
      regs_nxt[3] = `DEF_FB_LOW_CTL;
      regs_nxt[4] = `DEF_CDIS;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      drv_r <= 1'b0;
      regs_r[0] <= `DEF_DIV_AB;
      regs_r[1] <= `DEF_DIV_C;
      regs_r[2] <= `DEF_FB_HIGH;
      regs_r[3] <= `DEF_FB_LOW_CTL;
      regs_r[4] <= `DEF_CDIS;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      drv_r <= drv_nxt;
      for (int i = 0; i <= 4; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = drv_r;
  // ****************************************************************
  // Divider and output enable presentation
  // ****************************************************************
  logic [10:0] fb_field, fb_nxt, fb_r;
  logic [7:0] div_ab_nxt, div_c_nxt, div_ab_r, div_c_r;
  logic [1:0] ref_nxt, ref_r;
  logic [3:0] cen_nxt, cen_r;
  logic margin_on, fb_ok_r, margin_r;
  assign fb_field = {regs_r[2], regs_r[3][7:5]};
  assign margin_on = regs_r[3][`MARGIN_BIT];
  always_comb begin
    // Written dividers only steer the synthesizer once margining is on.
    div_ab_nxt = margin_on ? regs_r[0] : `DEF_DIV_AB;
    div_c_nxt = margin_on ? regs_r[1] : `DEF_DIV_C;
    fb_nxt = margin_on ? fb_field : `DEF_FB;
    ref_nxt = {2{ref_en_s}} & ~{regs_r[3][`REF1_DIS_BIT], regs_r[3][`REF0_DIS_BIT]};
    cen_nxt = {4{c_en_s}} & ~regs_r[4][7:4];
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      div_ab_r <= `DEF_DIV_AB;
      div_c_r <= `DEF_DIV_C;
      fb_r <= `DEF_FB;
      fb_ok_r <= 1'b1;
      margin_r <= 1'b0;
      ref_r <= 2'h0;
      cen_r <= 4'h0;
    end else begin
      div_ab_r <= div_ab_nxt;
      div_c_r <= div_c_nxt;
      fb_r <= fb_nxt;
      fb_ok_r <= (fb_nxt >= `FB_MIN) && (fb_nxt <= `FB_MAX);
      margin_r <= margin_on;
      ref_r <= ref_nxt;
      cen_r <= cen_nxt;
    end
  end
  assign divider_banks_ab = div_ab_r;
  assign divider_bank_c = div_c_r;
  assign feedback_divider = fb_r;
  assign feedback_in_range = fb_ok_r;
  assign margin_enable = margin_r;
  assign reference_out_zero = ref_r[0];
  assign reference_out_one = ref_r[1];
  assign bank_c_out_en = cen_r;
endmodule : synth_cfg_device

// >>> hdl/synth_cfg_host.sv
// Host end: two-wire master running block writes and block reads.
// Assumes a user that holds write data ready and takes read bytes at once.
`include "synth_cfg_consts.svh"
module synth_cfg_host
  import synth_cfg_pkg::*;
#(
  parameter int QUARTER_CYC = `SCL_QUARTER_CYC
) (
  input wire logic clk,
  input wire logic reset,
  two_wire_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_addr_sel,
  input wire logic [7:0] cmd_ptr,
  input wire logic [2:0] cmd_count,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic nack_seen
);
  // ****************************************************************
  // Bit timing
  // ****************************************************************
  logic sda_s;
  pin_sync #(.WIDTH(1)) u_sync (
    .clk(clk),
    .reset(reset),
    .pin(bus.sda),
    .sync(sda_s)
  );
  host_state_t st_r, st_nxt;
  logic [15:0] q_r, q_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [3:0] byte_r, byte_nxt;
  logic [3:0] last_r, last_nxt;
  logic rw_r, rw_nxt, sel_r, sel_nxt;
  logic [7:0] ptr_r, ptr_nxt, tx_r, tx_nxt, rx_r, rx_nxt;
  logic sda_drv_r, sda_drv_nxt, scl_drv_r, scl_drv_nxt;
  logic nack_r, nack_nxt, rdv_r, rdv_nxt;
  logic tick, rd_byte, last_byte;
  logic [7:0] src;
  assign tick = (q_r == 16'(QUARTER_CYC - 1));
  assign rd_byte = rw_r && (byte_r >= 4'h2);
  assign last_byte = (byte_r == last_r);
  assign cmd_ready = (st_r == M_IDLE);
  assign wr_take = (st_r == M_BIT) && tick && (ph_r == 2'h0) && (bit_r == 4'h0)
                   && (byte_r >= 4'h2) && !rw_r;
  always_comb begin
    unique case (byte_r)
      4'h0: src = {`SLAVE_ADDR_HIGH, sel_r, rw_r};
      4'h1: src = ptr_r;
      default: src = wr_data;
    endcase
  end
  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    q_nxt = tick ? 16'h0000 : q_r + 16'h0001;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    last_nxt = last_r;
    rw_nxt = rw_r;
    sel_nxt = sel_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    sda_drv_nxt = sda_drv_r;
    scl_drv_nxt = scl_drv_r;
    nack_nxt = nack_r;
    rdv_nxt = 1'b0;
    if (st_r == M_IDLE) begin
      q_nxt = 16'h0000;
      if (cmd_valid) begin
        st_nxt = M_START;
        ph_nxt = 2'h0;
        rw_nxt = cmd_read;
        sel_nxt = cmd_addr_sel;
        ptr_nxt = cmd_ptr;
        last_nxt = {1'b0, cmd_count} + 4'h1;
        byte_nxt = 4'h0;
        bit_nxt = 4'h0;
        nack_nxt = 1'b0;
      end
    end else if (tick) begin
      ph_nxt = ph_r + 2'h1;
      unique case (st_r)
        M_START: begin
          if (ph_r == 2'h0) begin
            sda_drv_nxt = 1'b1;
          end else begin
            scl_drv_nxt = 1'b1;
            st_nxt = M_BIT;
            ph_nxt = 2'h0;
          end
        end
        M_BIT: begin
          unique case (ph_r)
            2'h0: begin
              if (bit_r == `BYTE_BITS) begin
                sda_drv_nxt = rd_byte && !last_byte;
              end else if (rd_byte) begin
                sda_drv_nxt = 1'b0;
              end else if (bit_r == 4'h0) begin
                tx_nxt = src;
                sda_drv_nxt = ~src[7];
              end else begin
                sda_drv_nxt = ~tx_r[7];
              end
            end
            2'h1: scl_drv_nxt = 1'b0;
            2'h2: begin
              if (bit_r != `BYTE_BITS) begin
                rx_nxt = {rx_r[6:0], sda_s};
              end else if (rd_byte) begin
                rdv_nxt = 1'b1;
              end else if (sda_s) begin
                nack_nxt = 1'b1;
              end
            end
            default: begin
              scl_drv_nxt = 1'b1;
              tx_nxt = {tx_r[6:0], 1'b0};
              if (bit_r == `BYTE_BITS) begin
                bit_nxt = 4'h0;
                byte_nxt = byte_r + 4'h1;
                if (nack_r || last_byte) begin
                  st_nxt = M_STOP;
                end
              end else begin
                bit_nxt = bit_r + 4'h1;
              end
            end
          endcase
        end
        M_STOP: begin
          unique case (ph_r)
            2'h0: sda_drv_nxt = 1'b1;
            2'h1: scl_drv_nxt = 1'b0;
            2'h2: sda_drv_nxt = 1'b0;
            default: st_nxt = M_IDLE;
          endcase
        end
        default: st_nxt = M_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= M_IDLE;
      q_r <= 16'h0000;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      byte_r <= 4'h0;
      last_r <= 4'h0;
      rw_r <= 1'b0;
      sel_r <= 1'b0;
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      sda_drv_r <= 1'b0;
      scl_drv_r <= 1'b0;
      nack_r <= 1'b0;
      rdv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      q_r <= q_nxt;
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      last_r <= last_nxt;
      rw_r <= rw_nxt;
      sel_r <= sel_nxt;
      ptr_r <= ptr_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      sda_drv_r <= sda_drv_nxt;
      scl_drv_r <= scl_drv_nxt;
      nack_r <= nack_nxt;
      rdv_r <= rdv_nxt;
    end
  end
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_drv_r;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_drv_r;
  assign rd_data = rx_r;
  assign rd_valid = rdv_r;
  assign nack_seen = nack_r;
endmodule : synth_cfg_host

// >>> tb/synth_cfg_link_assertions.sv
// Checker of the two-wire link between the host end and the device end.
// Assumes QUARTER_CYC of 8 in the host, so every scl phase spans at least 16 cycles.
module synth_cfg_link_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ****************
  // Link rules
  // ****************
  chk_reset_quiet: assert property ($fell(reset) |-> !m_scl_oe && !m_sda_oe && !d_sda_oe)
    else $error("link driven after reset");
  chk_dev_steady_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("device moved sda while scl high");
  chk_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
    else $error("scl low phase too short");
  chk_scl_high_min: assert property ($rose(scl) |=> scl [*7])
    else $error("scl high phase too short");
  chk_scl_low_max: assert property ($fell(scl) |-> ##[1:40] scl)
    else $error("scl held low too long");
  chk_dev_no_start: assert property ($fell(sda) && scl |-> m_sda_oe && !d_sda_oe)
    else $error("start not made by host");
  chk_dev_release: assert property ($rose(d_sda_oe) |-> ##[1:400] !d_sda_oe)
    else $error("device never released sda");
  chk_dev_hold_bit: assert property ($rose(d_sda_oe) |=> d_sda_oe [*8])
    else $error("device bit too short");
  chk_host_frames: assert property (scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe))
    else $error("sda changed under scl high");
  // Main scenarios: device ack or data, start and stop.
  cov_dev_drive: cover property ($rose(d_sda_oe));
  cov_start: cover property ($fell(sda) && scl);
  cov_stop: cover property ($rose(sda) && scl);
endmodule : synth_cfg_link_checker

// >>> tb/tb_clock_synth_i2c_config_port.sv
// Testbench of the configuration port: host end and device end joined by the link.
// Assumes the hdl files are compiled first; the host runs with a short scl quarter.
module tb_clock_synth_i2c_config_port
  import synth_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals
  // ****************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_addr_sel = 1'b0;
  logic [7:0] cmd_ptr = 8'h00;
  logic [2:0] cmd_count = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic strap = 1'b0;
  logic spread = 1'b0;
  logic mr = 1'b0;
  logic ref_en = 1'b1;
  logic c_en = 1'b1;
  logic cmd_ready, wr_take, rd_valid, nack_seen, in_range, margin, ref0, ref1;
  logic [7:0] rd_data, div_ab, div_c;
  logic [10:0] fb;
  logic [3:0] c_out_en;
  logic [7:0] wbuf [5];
  logic [7:0] exp_q [$];
  int wi = 0;
  int num_errors = 0;
  int num_checks = 0;
  two_wire_if bus ();
  synth_cfg_host #(.QUARTER_CYC(8)) u_synth_cfg_host (.clk(clk), .reset(reset), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr_sel(cmd_addr_sel),
    .cmd_ptr(cmd_ptr), .cmd_count(cmd_count), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
    .rd_valid(rd_valid), .nack_seen(nack_seen));
  synth_cfg_device u_synth_cfg_device (.clk(clk), .reset(reset), .bus(bus), .addr_select_strap(strap),
    .spread_enable_pin(spread), .master_reset_pin(mr), .reference_enable_pin(ref_en),
    .bank_c_enable_pin(c_en), .divider_banks_ab(div_ab), .divider_bank_c(div_c), .feedback_divider(fb),
    .feedback_in_range(in_range), .margin_enable(margin), .reference_out_zero(ref0),
    .reference_out_one(ref1), .bank_c_out_en(c_out_en));
  synth_cfg_link_checker u_synth_cfg_link_checker (.clk(clk), .reset(reset), .m_scl_oe(bus.m_scl_oe),
    .m_sda_oe(bus.m_sda_oe), .d_sda_oe(bus.d_sda_oe), .scl(bus.scl), .sda(bus.sda));
  initial begin
    forever #2 clk = ~clk;
  end
  // ****************
  // Checking and transfers
  // ****************
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte
  task automatic cmp_out(input string what, input logic [10:0] exp, input logic [10:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_out
  task automatic final_report();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // The host pulls write bytes one at a time, so the next one is staged after each take.
  always @(posedge clk) begin
    if (wr_take === 1'b1) wi = wi + 1;
    wr_data <= wbuf[wi % 5];
  end
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      cmp_byte("read data", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX, rd_data);
    end
  end
  task automatic run(input logic rd, input logic sel, input logic [7:0] ptr, input logic [2:0] cnt);
    int n;
    n = 0;
    wi = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr_sel <= sel;
    cmd_ptr <= ptr;
    cmd_count <= cnt;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 4000);
    cmp_out("command done", 11'h001, {10'h000, cmd_ready});
    cmp_out("link idle", 11'h003, {9'h000, bus.scl, bus.sda});
  endtask : run
  task automatic wr(input logic [7:0] ptr, input logic [2:0] cnt, input logic [39:0] d);
    for (int k = 0; k < 5; k++) wbuf[k] = d[39-8*k -: 8];
    run(1'b0, strap, ptr, cnt);
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input logic [2:0] cnt, input logic [39:0] d);
    for (int k = 0; k < cnt; k++) exp_q.push_back(d[39-8*k -: 8]);
    run(1'b1, strap, ptr, cnt);
  endtask : rd
  task automatic chk_outs(input logic [10:0] f, input logic m, input logic [5:0] ab, input logic [5:0] c,
      input logic [3:0] ce, input logic [1:0] rf);
    cmp_out("feedback", f, fb);
    cmp_out("margin", {10'h000, m}, {10'h000, margin});
    cmp_out("in range", 11'h001, {10'h000, in_range});
    cmp_out("divider ab", {5'h00, ab}, {5'h00, div_ab[6:1]});
    cmp_out("divider c", {5'h00, c}, {5'h00, div_c[6:1]});
    cmp_out("c enables", {7'h00, ce}, {7'h00, c_out_en});
    cmp_out("ref enables", {9'h000, rf}, {9'h000, ref1, ref0});
  endtask : chk_outs
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    final_report();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    int unsigned r;
    logic [7:0] a;
    logic [7:0] cc;
    r = $urandom(32'hEB0477A0);
    r = $urandom();
    a = r[7:0] & 8'h7E;
    cc = r[15:8] & 8'h7E;
    @(posedge clk);
    strap <= r[16];
    repeat (15) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h00, 3'd5, 40'h1E1E50000B);
    chk_outs(11'h280, 1'b0, 6'h0F, 6'h0F, 4'hF, 2'b11);
    wr(8'h00, 3'd5, {a, cc, 8'h60, 8'h13, 8'hA5});
    rd(8'h00, 3'd5, {a, cc, 8'h60, 8'h13, 8'hAB});
    chk_outs(11'h300, 1'b1, a[6:1], cc[6:1], 4'h5, 2'b00);
    wr(8'h02, 3'd1, {8'hFF, 32'h00000000});
    cmp_out("in range", 11'h000, {10'h000, in_range});
    wr(8'h02, 3'd2, {8'h00, 8'h90, 24'h000000});
    chk_outs(11'h004, 1'b1, a[6:1], cc[6:1], 4'h5, 2'b11);
    c_en <= 1'b0;
    ref_en <= 1'b0;
    repeat (8) @(posedge clk);
    chk_outs(11'h004, 1'b1, a[6:1], cc[6:1], 4'h0, 2'b00);
    c_en <= 1'b1;
    ref_en <= 1'b1;
    spread <= 1'b1;
    repeat (8) @(posedge clk);
    wr(8'h01, 3'd3, {8'h0C, 8'h7F, 8'hF0, 16'h0000});
    rd(8'h01, 3'd3, {8'h0C, 8'h00, 8'h90, 16'h0000});
    cmp_out("feedback", 11'h004, fb);
    spread <= 1'b0;
    wr(8'h04, 3'd2, {8'h50, 8'hFF, 24'h000000});
    rd(8'h04, 3'd3, {8'h5B, 32'h00000000});
    run(1'b1, ~strap, 8'h00, 3'd1);
    cmp_out("refused", 11'h001, {10'h000, nack_seen});
    run(1'b0, strap, 8'h00, 3'd0);
    cmp_out("answered", 11'h000, {10'h000, nack_seen});
    mr <= 1'b1;
    repeat (8) @(posedge clk);
    mr <= 1'b0;
    repeat (8) @(posedge clk);
    rd(8'h00, 3'd5, 40'h1E1E50000B);
    chk_outs(11'h280, 1'b0, 6'h0F, 6'h0F, 4'hF, 2'b11);
    cmp_out("pending reads", 11'h000, 11'(exp_q.size()));
    final_report();
  end
endmodule : tb_clock_synth_i2c_config_port
